// ===== design/nvm_err_pkg.sv
// Constants and types for the non-volatile memory bit-error reporting block.
// Assumes a 32-bit AXI4-Lite register bus and an error-detection unit on the same clock.
package nvm_err_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_ERR      = 8'h04;
  localparam logic [7:0] OFF_RSTVEC   = 8'h08;
  localparam logic [7:0] OFF_NMIVEC   = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h18;

  // ************************************************************
  // Field layouts and widths
  // ************************************************************
  localparam int CTRL_W = 4;
  localparam int ERR_W  = 2;
  localparam int IRQ_W  = 3;
  localparam int VEC_W  = 8;

  // Control register; the last field listed sits in bit 0.
  typedef struct packed {
    logic corr_irq_en;
    logic uncorr_irq_en;
    logic uncorr_reset_en;
    logic power_en;
  } ctrl_t;

  // Events reported by the error-detection logic, one-cycle pulses.
  typedef struct packed {
    logic corr;
    logic uncorr;
  } ecc_evt_t;

  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h1;

  // ************************************************************
  // Vector codes
  // ************************************************************
  localparam logic [VEC_W-1:0] VEC_NONE       = 8'h00;
  localparam logic [VEC_W-1:0] RST_SRC_UNCORR = 8'h1c;
  localparam logic [VEC_W-1:0] NMI_SRC_UNCORR = 8'h02;
  localparam logic [VEC_W-1:0] NMI_SRC_CORR   = 8'h04;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== design/sticky_flags.sv
// Bank of sticky flags: set by hardware events, cleared per bit by software.
// Assumes set and clear arrive on the same clock; rst_n clears the whole bank at once, synchronously.
`timescale 1ns/1ps
module sticky_flags #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Flag control
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] flags
);

  logic [W-1:0] flags_r;
  logic [W-1:0] flags_nxt;

  // Set wins over a clear in the same cycle so no event is lost.
  for (genvar i = 0; i < W; i++)
  begin : g_flag
    always_comb
    begin
      flags_nxt[i] = set[i] | (flags_r[i] & ~clr[i]);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      flags_r <= '0;
    else
      flags_r <= flags_nxt;
  end

  assign flags = flags_r;

endmodule

// ===== design/nvm_err_report.sv
// Bit-error reporting for the non-volatile memory controller, with AXI4-Lite registers.
// Assumes ecc_evt pulses come from logic on clk_sys, and that the system reset and
// NMI logic outside act on power_up_clear_reset and nmi_req.
//
// Contract
// [RQ1] An uncorrectable read error sets a sticky uncorrectable flag.
// [RQ2] With reset enable set, uncorrectable error raises power-up-clear and loads reset code.
// [RQ3] With irq enable set and reset enable clear, uncorrectable error raises NMI code.
// [RQ4] With correctable irq enable set, correctable error raises NMI with its code.
// [RQ5] The uncorrectable flag survives a power-up-clear reset for polling.
// [RQ6] Software clears each error flag individually; flags stay set until cleared.
// [RQ7] Writing zero to the power enable switches off the memory supply.
// [RQ8] Error-caused reset sets the flag and records nonzero source; zero means none.
// [RQ9] A corrected single-bit error sets a sticky correctable flag.
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module nvm_err_report
  import nvm_err_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Error detection events
  input  wire ecc_evt_t          ecc_evt,
  // System side
  output logic                   nvm_power_en,
  output logic                   power_up_clear_reset,
  output logic                   nmi_req,
  output logic                   irq
);
  // ************************************************************
  // Bus write path
  // ************************************************************
  logic              aw_got_r, aw_got_nxt;
  logic              w_got_r, w_got_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0]       wdata_r, wdata_nxt;
  logic              wlo_r, wlo_nxt;
  logic              bvalid_r, bvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt;
  logic              wr_do;
  logic              wr_ctrl, wr_err, wr_irqclr, wr_irqen;
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign wr_do         = aw_got_r && w_got_r;
  always_comb
  begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt  = wdata_r;
    wlo_nxt    = wlo_r;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt  = bresp_r;
    wr_ctrl    = 1'b0;
    wr_err     = 1'b0;
    wr_irqclr  = 1'b0;
    wr_irqen   = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wlo_nxt   = s_axi_wstrb[0];
    end
    if (wr_do)
    begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = RESP_OKAY;
      // All fields sit in byte lane 0, so other lanes change nothing.
      if (awaddr_r == OFF_CTRL)
        wr_ctrl = wlo_r;
      else if (awaddr_r == OFF_ERR)
        wr_err = wlo_r;
      else if (awaddr_r == OFF_IRQ_CLR)
        wr_irqclr = wlo_r;
      else if (awaddr_r == OFF_IRQ_EN)
        wr_irqen = wlo_r;
      else if (awaddr_r != OFF_RSTVEC && awaddr_r != OFF_NMIVEC && awaddr_r != OFF_IRQ_STAT)
        bresp_nxt = RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= '0;
      wdata_r  <= '0;
      wlo_r    <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end
    else
    begin
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r  <= wdata_nxt;
      wlo_r    <= wlo_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  // ************************************************************
  // Error handling core
  // ************************************************************
  ctrl_t             ctrl_r, ctrl_nxt;
  logic [VEC_W-1:0]  rstvec_r, rstvec_nxt;
  logic [VEC_W-1:0]  nmivec_r, nmivec_nxt;
  logic              puc_r, puc_nxt;
  logic [IRQ_W-1:0]  irq_en_r, irq_en_nxt;
  logic [ERR_W-1:0]  err_flags;
  logic [IRQ_W-1:0]  irq_stat;
  logic              puc_now, nmi_uncorr, nmi_corr;
  logic              rd_rstvec, rd_nmivec;
  // [RQ2] Reset on uncorrectable
  assign puc_now    = ecc_evt.uncorr && ctrl_r.uncorr_reset_en;
  // [RQ3] NMI when reset disabled
  assign nmi_uncorr = ecc_evt.uncorr && !ctrl_r.uncorr_reset_en && ctrl_r.uncorr_irq_en;
  // [RQ4] NMI on correctable
  assign nmi_corr   = ecc_evt.corr && ctrl_r.corr_irq_en;
  always_comb
  begin
    ctrl_nxt   = ctrl_r;
    rstvec_nxt = rstvec_r;
    nmivec_nxt = nmivec_r;
    irq_en_nxt = irq_en_r;
    puc_nxt    = puc_now;
    if (wr_irqen)
      irq_en_nxt = wdata_r[IRQ_W-1:0];
    // [RQ7] Power enable write
    if (wr_ctrl)
      ctrl_nxt = ctrl_t'(wdata_r[CTRL_W-1:0]);
    // Reading a vector consumes it, as an interrupt vector read would.
    if (rd_rstvec)
      rstvec_nxt = VEC_NONE;
    if (rd_nmivec)
      nmivec_nxt = VEC_NONE;
    if (nmi_corr && nmivec_r != NMI_SRC_UNCORR)
      nmivec_nxt = NMI_SRC_CORR;
    // [RQ3] Uncorrectable outranks correctable
    if (nmi_uncorr)
      nmivec_nxt = NMI_SRC_UNCORR;
    // [RQ8] Nonzero reset source
    if (puc_now)
    begin
      ctrl_nxt   = ctrl_t'(CTRL_RST);
      rstvec_nxt = RST_SRC_UNCORR;
      nmivec_nxt = VEC_NONE;
    end
  end
  // [RQ5] Flags are not in this reset
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctrl_r   <= ctrl_t'(CTRL_RST);
      rstvec_r <= VEC_NONE;
      nmivec_r <= VEC_NONE;
      irq_en_r <= '0;
      puc_r    <= 1'b0;
    end
    else
    begin
      ctrl_r   <= ctrl_nxt;
      rstvec_r <= rstvec_nxt;
      nmivec_r <= nmivec_nxt;
      irq_en_r <= irq_en_nxt;
      puc_r    <= puc_nxt;
    end
  end

  // [RQ1] [RQ9] [RQ6] Sticky error flags, cleared by writing ones
  sticky_flags #(.W(ERR_W)) u_err_flags (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set     ({ecc_evt.corr, ecc_evt.uncorr}),
    .clr     (wr_err ? wdata_r[ERR_W-1:0] : {ERR_W{1'b0}}),
    .flags   (err_flags)
  );
  sticky_flags #(.W(IRQ_W)) u_irq_stat (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set     ({puc_now, ecc_evt.corr, ecc_evt.uncorr}),
    .clr     (wr_irqclr ? wdata_r[IRQ_W-1:0] : {IRQ_W{1'b0}}),
    .flags   (irq_stat)
  );
  // [RQ7] Supply follows the enable
  assign nvm_power_en         = ctrl_r.power_en;
  assign power_up_clear_reset = puc_r;
  assign nmi_req              = nmivec_r != VEC_NONE;
  assign irq                  = |(irq_stat & irq_en_r);
  // ************************************************************
  // Bus read path
  // ************************************************************
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic        ar_fire;
  assign s_axi_arready = !rvalid_r;
  assign ar_fire       = s_axi_arvalid && !rvalid_r;
  assign rd_rstvec     = ar_fire && s_axi_araddr == OFF_RSTVEC;
  assign rd_nmivec     = ar_fire && s_axi_araddr == OFF_NMIVEC;
  always_comb
  begin
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (ar_fire)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      rdata_nxt  = '0;
      if (s_axi_araddr == OFF_CTRL)
        rdata_nxt[CTRL_W-1:0] = ctrl_r;
      else if (s_axi_araddr == OFF_ERR)
        rdata_nxt[ERR_W-1:0] = err_flags;
      else if (s_axi_araddr == OFF_RSTVEC)
        rdata_nxt[VEC_W-1:0] = rstvec_r;
      else if (s_axi_araddr == OFF_NMIVEC)
        rdata_nxt[VEC_W-1:0] = nmivec_r;
      else if (s_axi_araddr == OFF_IRQ_STAT)
        rdata_nxt[IRQ_W-1:0] = irq_stat;
      else if (s_axi_araddr == OFF_IRQ_EN)
        rdata_nxt[IRQ_W-1:0] = irq_en_r;
      else if (s_axi_araddr != OFF_IRQ_CLR)
        rresp_nxt = RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end
    else
    begin
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;
  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_uncorr_reset;
    ecc_evt.uncorr && ctrl_r.uncorr_reset_en;
  endsequence
  sequence s_puc_seen;
    power_up_clear_reset && rstvec_r == RST_SRC_UNCORR && err_flags[0];
  endsequence
  property p_uncorr_flag;
    ecc_evt.uncorr |=> err_flags[0];
  endproperty
  a_uncorr_flag: assert property (p_uncorr_flag) else $error("uncorrectable flag not set"); // [RQ1]
  property p_puc;
    s_uncorr_reset |=> s_puc_seen ##1 !power_up_clear_reset;
  endproperty
  a_puc: assert property (p_puc) else $error("power-up-clear or reset code missing"); // [RQ2]
  property p_nmi_uncorr;
    nmi_uncorr |=> nmi_req && nmivec_r == NMI_SRC_UNCORR && !power_up_clear_reset;
  endproperty
  a_nmi_uncorr: assert property (p_nmi_uncorr) else $error("uncorrectable NMI code missing"); // [RQ3]
  property p_nmi_corr;
    nmi_corr && !ecc_evt.uncorr && nmivec_r != NMI_SRC_UNCORR |=> nmivec_r == NMI_SRC_CORR;
  endproperty
  a_nmi_corr: assert property (p_nmi_corr) else $error("correctable NMI code missing"); // [RQ4]
  property p_flag_survives;
    power_up_clear_reset && !wr_err |=> err_flags[0];
  endproperty
  a_flag_survives: assert property (p_flag_survives) else $error("flag lost across reset"); // [RQ5]
  property p_flags_hold;
    err_flags[1] && !wr_err |=> err_flags[1];
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("correctable flag dropped"); // [RQ6]
  property p_flag_clear;
    wr_err && wdata_r[0] && !ecc_evt.uncorr |=> !err_flags[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by write"); // [RQ6]
  property p_power_off;
    wr_ctrl && !wdata_r[0] && !puc_now |=> !nvm_power_en;
  endproperty
  a_power_off: assert property (p_power_off) else $error("supply not switched off"); // [RQ7]
  property p_rst_src;
    power_up_clear_reset |-> rstvec_r != VEC_NONE;
  endproperty
  a_rst_src: assert property (p_rst_src) else $error("reset source left zero"); // [RQ8]
  // A clear write may follow at once, so only the first cycle after the event is promised.
  property p_corr_flag;
    ecc_evt.corr |=> err_flags[1];
  endproperty
  a_corr_flag: assert property (p_corr_flag) else $error("correctable flag not set"); // [RQ9]
  property p_wr_resp;
    wr_do |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");

endmodule

// ===== verif/sys_partner.sv
// Far-side model of the system reset and NMI logic that watch the error reporter.
// Assumes power_up_clear_reset is a one-cycle pulse and nmi_req a level, both on clk_sys.
`timescale 1ns/1ps
module sys_partner (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Requests from the reporter
  input  wire logic power_up_clear_reset,
  input  wire logic nmi_req,
  // Observation
  output int        puc_count,
  output int        nmi_count
);
  logic nmi_seen_r;

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      nmi_seen_r <= 1'b0;
      nmi_count  <= 0;
    end
    else
    begin
      nmi_seen_r <= nmi_req;
      if (nmi_req === 1'b1 && nmi_seen_r === 1'b0)
        nmi_count <= nmi_count + 1;
    end
  end

  always @(posedge clk_sys)
  begin
    if (!rst_n)
      puc_count <= 0;
    else if (power_up_clear_reset === 1'b1)
      puc_count <= puc_count + 1;
  end
endmodule

// ===== verif/nvm_bit_error_reporting_test.sv
// Self-checking bench for the error reporter against a register-level model.
// Assumes the package map and codes; the bench is the only AXI4-Lite master.
`timescale 1ns/1ps
module nvm_bit_error_reporting_test;
  import nvm_err_pkg::*;
  logic        clk_sys = 0;
  logic        rst_n = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  ecc_evt_t    ecc_evt = '0;
  logic        nvm_power_en, power_up_clear_reset, nmi_req, irq;
  int          puc_count, nmi_count;
  int          bad_count = 0;
  int          tests_run = 0;
  logic [7:0]  m_ctrl, m_err, m_rv, m_nv, m_st, m_en;
  int          m_pc, m_nc;

  always #25 clk_sys = ~clk_sys;

  nvm_err_report uut (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ecc_evt(ecc_evt), .nvm_power_en(nvm_power_en),
    .power_up_clear_reset(power_up_clear_reset), .nmi_req(nmi_req), .irq(irq));

  sys_partner far_end (.clk_sys(clk_sys), .rst_n(rst_n), .power_up_clear_reset(power_up_clear_reset),
    .nmi_req(nmi_req), .puc_count(puc_count), .nmi_count(nmi_count));

  // ************************************************************
  // Comparison and bus tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [1:0] resp_of(input logic [7:0] a);
    return (a <= OFF_IRQ_EN && a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge clk_sys);
      if (!ad && s_axi_awready === 1'b1)
      begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1)
      begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do
    begin
      @(posedge clk_sys);
    end while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, resp_of(a));
    s_axi_bready <= 1'b0;
    if (s[0])
    begin
      if (a == OFF_CTRL) m_ctrl = d[3:0];
      if (a == OFF_ERR) m_err &= ~d[1:0];
      if (a == OFF_IRQ_CLR) m_st &= ~d[2:0];
      if (a == OFF_IRQ_EN) m_en = d[2:0];
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic [31:0] e;
    e = 0;
    case (a)
      OFF_CTRL: e = m_ctrl;
      OFF_ERR: e = m_err;
      OFF_RSTVEC: e = m_rv;
      OFF_NMIVEC: e = m_nv;
      OFF_IRQ_STAT: e = m_st;
      OFF_IRQ_EN: e = m_en;
      default: e = 0;
    endcase
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do
    begin
      @(posedge clk_sys);
    end while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, resp_of(a));
    s_axi_rready <= 1'b0;
    if (a == OFF_RSTVEC) m_rv = 0;
    if (a == OFF_NMIVEC) m_nv = 0;
  endtask

  // Reading a vector clears it, so level outputs are compared after every event and at chosen points in the sequence.
  task automatic sc();
    #1;
    chk(nvm_power_en, m_ctrl[0]);
    chk(irq, |(m_st & m_en));
    chk(nmi_req, m_nv != 0);
    chk(puc_count, m_pc);
    chk(nmi_count, m_nc);
  endtask

  task automatic ev(input logic [1:0] e);
    logic       p;
    logic [7:0] was;
    p = e[0] && m_ctrl[1];
    was = m_nv;
    @(posedge clk_sys);
    ecc_evt <= e;
    @(posedge clk_sys);
    ecc_evt <= '0;
    if (e[0]) m_err |= 8'h01;
    if (e[1]) m_err |= 8'h02;
    m_st |= {p, e[1], e[0]};
    if (p)
    begin
      m_rv = RST_SRC_UNCORR;
      m_ctrl = CTRL_RST;
      m_nv = VEC_NONE;
      m_pc++;
    end
    else if (e[0] && m_ctrl[2])
      m_nv = NMI_SRC_UNCORR;
    else if (e[1] && m_ctrl[3] && m_nv != NMI_SRC_UNCORR)
      m_nv = NMI_SRC_CORR;
    if (was == 8'h00 && m_nv != 8'h00) m_nc++;
    #1;
    chk(power_up_clear_reset, p);
    @(posedge clk_sys);
    sc();
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ************************************************************
  // Watchdog and main sequence
  // ************************************************************
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    bad_count++;
    tally_and_finish();
  end

  initial
  begin
    void'($urandom(90));
    {m_err, m_rv, m_nv, m_st, m_en, m_pc} = '0;
    m_nc = 0;
    m_ctrl = CTRL_RST;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int a = 0; a <= 32; a += 4)
      rd(a[7:0]); // zero vector after reset
    sc(); // supply on after reset
    wr(OFF_IRQ_EN, 32'h7, 4'hf);
    wr(OFF_RSTVEC, 32'hff, 4'hf);
    wr(8'h24, 32'h1, 4'hf);
    wr(OFF_CTRL, 32'h0, 4'hf);
    sc(); // supply switched off
    wr(OFF_CTRL, 32'h3, 4'h0);
    rd(OFF_CTRL);
    wr(OFF_CTRL, 32'h7, 4'hf);
    ev(2'h1); // reset path wins over NMI
    rd(OFF_ERR); // flag survives reset
    rd(OFF_RSTVEC); // nonzero source
    rd(OFF_RSTVEC); // cleared by read
    rd(OFF_CTRL); // control restored
    rd(OFF_IRQ_STAT);
    wr(OFF_CTRL, 32'h5, 4'hf);
    ev(2'h1); // uncorrectable NMI
    rd(OFF_NMIVEC); // code then cleared
    sc(); // request dropped
    wr(OFF_CTRL, 32'hd, 4'hf);
    ev(2'h2); // correctable NMI
    ev(2'h3); // uncorrectable code wins
    rd(OFF_NMIVEC); // code check
    wr(OFF_ERR, 32'h1, 4'hf);
    rd(OFF_ERR); // only one flag cleared
    wr(OFF_ERR, 32'h2, 4'hf);
    rd(OFF_ERR); // second flag cleared
    wr(OFF_IRQ_CLR, 32'h1, 4'hf);
    sc();
    wr(OFF_IRQ_EN, 32'h0, 4'hf);
    sc();
    // Reset enable stays clear here, so the model never has to cover a mid-loop reset.
    repeat (24)
    begin
      wr(OFF_CTRL, $urandom & 32'hd, 4'hf);
      ev(2'($urandom)); // random events
      rd(OFF_NMIVEC); // vector code
      rd(OFF_ERR); // flags held
      rd(OFF_IRQ_STAT);
      wr(OFF_ERR, $urandom & 32'h3, 4'hf);
      wr(OFF_IRQ_CLR, $urandom & 32'h7, 4'hf);
      wr(OFF_IRQ_EN, $urandom & 32'h7, 4'hf);
      rd(OFF_ERR); // individual clears
      sc();
    end
    tally_and_finish();
  end
endmodule
